// [rtl/see_pkg.sv]
// Constants for the two-wire serial memory write slave
package see_pkg;
  localparam int          CTRL_CODE_W   = 4;
  localparam int          SEL_W         = 3;
  localparam logic        RW_WRITE      = 1'b0;
  localparam int          DEV_CODE_MSB  = 7;
  localparam int          SEL_MSB       = 3;
  localparam int          RW_BIT        = 0;
  localparam int          ADDR_W        = 8;
  localparam int          PAGE_BYTES    = 16;
  localparam int          MEM_BYTES     = 256;
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          WCYC_TIME_US  = 5000;
  localparam int          WCYC_CYCLES   = (CLK_HZ / 1000) * WCYC_TIME_US / 1000;
  typedef enum logic [2:0] {
    SEE_IDLE, SEE_CTRL, SEE_ADDR, SEE_DATA, SEE_ACK, SEE_SKIP
  } see_state_e;
endpackage : see_pkg

// [rtl/see_eeprom_write.sv]
// Two-wire serial memory, write path with page buffer and timed commit
`timescale 1ns/1ns
module see_eeprom_write #(
  parameter int WCYC_CYCLES = see_pkg::WCYC_CYCLES,
  parameter int MEM_BYTES   = see_pkg::MEM_BYTES,
  parameter int PAGE_BYTES  = see_pkg::PAGE_BYTES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Straps
  input  wire logic       slave_select_pin_0,
  input  wire logic       slave_select_pin_1,
  input  wire logic       slave_select_pin_2,
  input  wire logic       write_protect,
  // Status and commit stream
  output logic            busy,
  output logic            commit_valid,
  output logic [7:0]      commit_addr,
  output logic [7:0]      commit_data,
  input  wire logic       commit_ready
);
  localparam int PW = $clog2(PAGE_BYTES);
  localparam int AW = see_pkg::ADDR_W;
  localparam int CW = $clog2(WCYC_CYCLES + 1);
  localparam logic [3:0] DEV_CODE = 4'h5; // Arbitrary type code

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: logic reads stage two, plus a third stage for clock and data
  logic [1:0] scl_s_q, sda_s_q, wp_s_q, ss0_s_q, ss1_s_q, ss2_s_q;
  logic       scl_q, sda_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      wp_s_q  <= 2'h3;
      ss0_s_q <= 2'h0;
      ss1_s_q <= 2'h0;
      ss2_s_q <= 2'h0;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end
    else
    begin
      scl_s_q <= {scl_s_q[0], scl_in};
      sda_s_q <= {sda_s_q[0], sda_in};
      wp_s_q  <= {wp_s_q[0], write_protect};
      ss0_s_q <= {ss0_s_q[0], slave_select_pin_0};
      ss1_s_q <= {ss1_s_q[0], slave_select_pin_1};
      ss2_s_q <= {ss2_s_q[0], slave_select_pin_2};
      scl_q   <= scl_s_q[1];
      sda_q   <= sda_s_q[1];
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  logic [2:0] pins;
  always_comb
  begin
    scl_rise = scl_s_q[1] & ~scl_q;
    scl_fall = ~scl_s_q[1] & scl_q;
    start_c  = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
    stop_c   = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];
    pins     = {ss2_s_q[1], ss1_s_q[1], ss0_s_q[1]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine
  see_pkg::see_state_e st_q, st_d, ret_q, ret_d;
  logic [7:0]    sh_q, sh_d;
  logic [3:0]    bit_q, bit_d;
  logic          ack_q, ack_d;
  logic          oe_q, oe_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [7:0]    page_q [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] dirty_q, dirty_d;
  logic          wr_pend_q, wr_pend_d;
  logic          wp_lat_q, wp_lat_d;
  logic          buf_we;
  logic [PW-1:0] buf_idx;
  // Commit side
  logic          busy_q, busy_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [PW:0]   cidx_q, cidx_d;
  logic          cmt_go;
  // Commit stream buffer
  logic [15:0]   fb_q [2];
  logic [15:0]   word_in;
  logic [15:0]   head_d;
  logic [1:0]    fcnt_q, fcnt_d;
  logic          fwr_q, fwr_d, frd_q, frd_d;
  logic          push, pop, cv_d;
  logic [PW-1:0] cslot;

  always_comb
  begin
    st_d      = st_q;
    ret_d     = ret_q;
    sh_d      = sh_q;
    bit_d     = bit_q;
    ack_d     = ack_q;
    oe_d      = oe_q;
    addr_d    = addr_q;
    dirty_d   = dirty_q;
    wr_pend_d = wr_pend_q;
    wp_lat_d  = wp_lat_q;
    buf_we    = 1'b0;
    buf_idx   = addr_q[PW-1:0];
    cmt_go    = 1'b0;
    if (start_c)
    begin
      st_d  = see_pkg::SEE_CTRL;
      bit_d = 4'h0;
      oe_d  = 1'b0;
      wr_pend_d = 1'b0;
    end
    else if (stop_c)
    begin
      st_d = see_pkg::SEE_IDLE;
      oe_d = 1'b0;
      if (wr_pend_q && !busy_q && !wp_lat_q && |dirty_q)
        cmt_go = 1'b1;
      wr_pend_d = 1'b0;
    end
    else
    begin
      unique case (st_q)
        see_pkg::SEE_IDLE, see_pkg::SEE_SKIP: ;
        see_pkg::SEE_CTRL, see_pkg::SEE_ADDR, see_pkg::SEE_DATA:
        begin
          if (scl_rise)
          begin
            sh_d  = {sh_q[6:0], sda_q};
            bit_d = bit_q + 4'h1;
          end
          if (scl_fall && bit_q == 4'h8)
          begin
            bit_d = 4'h0;
            ack_d = 1'b0;
            ret_d = st_q;
            if (st_q == see_pkg::SEE_CTRL)
            begin
              if (sh_q[see_pkg::DEV_CODE_MSB -: see_pkg::CTRL_CODE_W] ==
                  DEV_CODE &&
                  sh_q[see_pkg::SEL_MSB -: see_pkg::SEL_W] == pins &&
                  sh_q[see_pkg::RW_BIT] == see_pkg::RW_WRITE && !busy_q)
              begin
                ack_d = 1'b1;
                ret_d = see_pkg::SEE_ADDR;
                dirty_d = '0;
                wp_lat_d = wp_s_q[1];
              end
            end
            else if (st_q == see_pkg::SEE_ADDR)
            begin
              ack_d  = 1'b1;
              addr_d = sh_q;
              ret_d  = see_pkg::SEE_DATA;
            end
            else
            begin
              ack_d = 1'b1;
              buf_we = 1'b1;
              dirty_d[addr_q[PW-1:0]] = 1'b1;
              wr_pend_d = 1'b1;
              addr_d = {addr_q[AW-1:PW], addr_q[PW-1:0] + PW'(1)};
            end
            oe_d = ack_d;
            st_d = ack_d ? see_pkg::SEE_ACK : see_pkg::SEE_SKIP;
          end
        end
        see_pkg::SEE_ACK:
          if (scl_fall)
          begin
            oe_d = 1'b0;
            st_d = ret_q;
          end
      endcase
    end
  end

  // Array written one byte per handshake; one cycle covers the page
  always_comb
  begin
    busy_d = busy_q;
    cnt_d  = cnt_q;
    cidx_d = cidx_q;
    if (cmt_go)
    begin
      busy_d = 1'b1;
      cnt_d  = CW'(WCYC_CYCLES);
      cidx_d = '0;
    end
    else if (busy_q)
    begin
      if (cnt_q != '0)
        cnt_d = cnt_q - CW'(1);
      if (push)
        cidx_d = cidx_q + (PW+1)'(1);
      if (cnt_q == '0 && cidx_q == (PW+1)'(PAGE_BYTES) && !commit_valid)
        busy_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer on the commit stream, stalls on commit_ready
  // Unwritten slots go out as zero but keep their own page address
  always_comb
  begin
    cslot   = cidx_q[PW-1:0];
    push    = busy_q && cidx_q != (PW+1)'(PAGE_BYTES) && fcnt_q != 2'h2;
    pop     = commit_valid && commit_ready;
    word_in = {addr_q[AW-1:PW], cslot,
               page_q[cslot] & {8{dirty_q[cslot]}}};
    fcnt_d  = fcnt_q + {1'b0, push} - {1'b0, pop};
    fwr_d   = push ? ~fwr_q : fwr_q;
    frd_d   = pop ? ~frd_q : frd_q;
    cv_d    = fcnt_d != 2'h0;
    // Bypass, so the output shows the word that is written into the read slot this edge
    head_d  = (push && fwr_q == frd_d) ? word_in : fb_q[frd_d];
  end

  always_ff @(posedge clk)
  begin
    if (buf_we)
      page_q[buf_idx] <= sh_q;
    if (push)
      fb_q[fwr_q] <= word_in;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= see_pkg::SEE_IDLE;
      ret_q <= see_pkg::SEE_IDLE;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      addr_q <= '0;
      dirty_q <= '0;
      wr_pend_q <= 1'b0;
      wp_lat_q <= 1'b1;
      busy_q <= 1'b0;
      cnt_q <= '0;
      cidx_q <= '0;
      fcnt_q <= 2'h0;
      fwr_q <= 1'b0;
      frd_q <= 1'b0;
      commit_valid <= 1'b0;
      commit_addr <= 8'h00;
      commit_data <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      ret_q <= ret_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
      addr_q <= addr_d;
      dirty_q <= dirty_d;
      wr_pend_q <= wr_pend_d;
      wp_lat_q <= wp_lat_d;
      busy_q <= busy_d;
      cnt_q <= cnt_d;
      cidx_q <= cidx_d;
      fcnt_q <= fcnt_d;
      fwr_q <= fwr_d;
      frd_q <= frd_d;
      commit_valid <= cv_d;
      commit_addr <= head_d[15:8];
      commit_data <= head_d[7:0];
    end
  end

  always_comb
  begin
    sda_out = 1'b0;
    sda_oe  = oe_q;
    busy    = busy_q;
  end
endmodule : see_eeprom_write

// [verification/see_properties.sv]
// Concurrent checks on the serial memory write slave ports
`timescale 1ns/1ns
module see_props (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // Bus pins
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Straps
  input wire logic       slave_select_pin_0,
  input wire logic       slave_select_pin_1,
  input wire logic       slave_select_pin_2,
  input wire logic       write_protect,
  // Status and commit stream
  input wire logic       busy,
  input wire logic       commit_valid,
  input wire logic [7:0] commit_addr,
  input wire logic [7:0] commit_data,
  input wire logic       commit_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Release follows the next clock fall after the synchroniser delay
  sequence s_drop;
    ##[1:5] !sda_oe;
  endsequence
  a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("ack rose while clock high");
  a_ack_held: assert property ($rose(sda_oe) |-> sda_oe [*4])
    else $error("ack too short");
  a_ack_release: assert property (sda_oe && $fell(scl_in) |-> s_drop)
    else $error("ack not released");
  a_busy_no_ack: assert property (busy |-> !$rose(sda_oe))
    else $error("ack while busy");
  a_commit_busy: assert property (commit_valid |-> busy)
    else $error("commit outside write cycle");
  a_commit_stall: assert property (commit_valid && !commit_ready |=>
    commit_valid && $stable(commit_addr) && $stable(commit_data))
    else $error("stalled word lost");
  a_busy_drain: assert property ($fell(busy) |-> !commit_valid)
    else $error("busy fell with words pending");
  a_page_same: assert property (commit_valid && commit_ready |=>
    !commit_valid || commit_addr[7:4] == $past(commit_addr[7:4]))
    else $error("commit left the page");
endmodule : see_props

bind see_eeprom_write see_props u_props (.clk, .rst_n, .scl_in, .sda_in,
  .sda_out, .sda_oe, .slave_select_pin_0, .slave_select_pin_1,
  .slave_select_pin_2, .write_protect, .busy, .commit_valid, .commit_addr,
  .commit_data, .commit_ready);

// [verification/see_bus_master.sv]
// Bus master model: drives the clock line and its share of the data line
`timescale 1ns/1ns
module see_bus_master (
  // Clock
  input wire logic clk,
  // Bus
  output logic     scl,
  output logic     sda_drv,
  input wire logic sda_line
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Eight clocks a phase, well above the slave's minimum of four
  task automatic half;
    repeat (8) @(negedge clk);
  endtask : half
  task automatic start;
    sda_drv = 1'b0;
    half();
    scl = 1'b0;
    half();
  endtask : start
  // Also the recovery after a missing acknowledge
  task automatic stop;
    sda_drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask : stop
  task automatic wb(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sda_drv = b[i];
      half();
      scl = 1'b1;
      half();
      scl = 1'b0;
    end
    sda_drv = 1'b1;
    half();
    scl = 1'b1;
    repeat (4) @(negedge clk);
    ack = sda_line;
    repeat (4) @(negedge clk);
    scl = 1'b0;
  endtask : wb
endmodule : see_bus_master

// [verification/testbench.sv]
// Self-checking bench for the serial memory write slave
`timescale 1ns/1ns
module testbench;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ready = 1'b0;
  logic       wp = 1'b0;
  logic       scl, sda_drv, sda_oe, sdo, busy, cv, ack;
  logic [7:0] ca, cd;
  logic [7:0] mem [256];
  logic [7:0] bad [3] = '{8'h50, 8'h5b, 8'h3a};
  int         err_count = 0;
  int         compares = 0;
  int         ncom = 0;
  int         cyc = 0;
  // Pull-up on the data line: low when either side pulls
  wire        sda = sda_drv & (~sda_oe | sdo);
  always #20 clk = ~clk;
  see_bus_master m (.clk(clk), .scl(scl), .sda_drv(sda_drv),
    .sda_line(sda));
  see_eeprom_write #(.WCYC_CYCLES(400)) uut (.clk(clk), .rst_n(rst_n),
    .scl_in(scl), .sda_in(sda), .sda_out(sdo), .sda_oe(sda_oe),
    .slave_select_pin_0(1'b1), .slave_select_pin_1(1'b0),
    .slave_select_pin_2(1'b1), .write_protect(wp), .busy(busy),
    .commit_valid(cv), .commit_addr(ca), .commit_data(cd),
    .commit_ready(ready));
  // Array side stalls every other cycle
  always @(negedge clk) ready <= ~ready;
  always @(posedge clk)
  begin
    cyc++;
    if (cv && ready)
    begin
      mem[ca] <= cd;
      ncom++;
    end
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] b, input logic e, input string w);
    m.wb(b, ack);
    chk({7'h00, ack}, {7'h00, e}, w);
  endtask : wr
  task automatic end_sim;
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (4) @(negedge clk);
    m.start();
    wr(8'h5a, 1'b0, "ctrl");
    wr(8'h2e, 1'b0, "addr");
    for (int i = 1; i < 4; i++)
      wr(8'(8'h11 * i), 1'b0, "data");
    chk(8'(ncom), 8'h00, "early commit");
    m.stop();
    repeat (8) @(negedge clk);
    chk({7'h00, busy}, 8'h01, "busy");
    ack = 1'b1;
    // Poll with control bytes until the write cycle ends
    for (int i = 0; i < 20 && ack; i++)
    begin
      m.start();
      m.wb(8'h5a, ack);
      m.stop();
      if (i == 0)
        chk({7'h00, ack}, 8'h01, "busy poll");
    end
    chk({7'h00, ack}, 8'h00, "poll ack");
    chk(8'(ncom), 8'h10, "commits");
    chk(mem[8'h2e], 8'h11, "slot e");
    chk(mem[8'h2f], 8'h22, "slot f");
    chk(mem[8'h20], 8'h33, "slot 0");
    chk(mem[8'h25], 8'h00, "slot 5");
    foreach (bad[i])
    begin
      m.start();
      wr(bad[i], 1'b1, "refused");
      m.stop();
    end
    @(negedge clk) wp = 1'b1;
    m.start();
    wr(8'h5a, 1'b0, "wp ctrl");
    wr(8'h40, 1'b0, "wp addr");
    wr(8'h77, 1'b0, "wp data");
    m.stop();
    repeat (600) @(negedge clk);
    chk(8'(ncom), 8'h10, "wp commits");
    end_sim();
  end
endmodule : testbench
